// *** rtl/mdm_pkg.sv ***
package mdm_pkg;

    localparam int OPND_W     = 16;
    localparam int WIDE_W     = 32;
    localparam int DIV_BITS_PER_CYCLE = 2;
    localparam int DIV_CYCLES = 16;
    localparam int MUL_CYCLES = 1;
    localparam int MAC_CYCLES = 2;
    localparam int DIV_CNT_W  = 4;

    localparam logic [WIDE_W-1:0] ACC_RESET  = 32'h0000_0000;
    localparam logic [WIDE_W-1:0] WIDE_RESET = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        MDM_OP_MUL = 2'b00,
        MDM_OP_MAC = 2'b01,
        MDM_OP_DIV = 2'b11
    } mdm_op_t;

    typedef enum logic [1:0]
    {
        MDM_DIV_IDLE = 2'b00,
        MDM_DIV_RUN  = 2'b01,
        MDM_DIV_DONE = 2'b11
    } mdm_div_state_t;

endpackage

// *** rtl/mdm_div.sv ***
`timescale 1ns/1ps

module mdm_div
#(
    parameter int WIDTH  = mdm_pkg::WIDE_W,
    parameter int STEPS  = mdm_pkg::DIV_BITS_PER_CYCLE,
    parameter int CYCLES = mdm_pkg::DIV_CYCLES
)
(
    input  wire logic             i_sys_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_start,
    input  wire logic [WIDTH-1:0] i_dividend,
    input  wire logic [WIDTH-1:0] i_divisor,
    output logic                  o_busy,
    output logic                  o_done,
    output logic [WIDTH-1:0]      o_quotient,
    output logic [WIDTH-1:0]      o_remainder
);
    import mdm_pkg::*;

    generate
        if (STEPS * CYCLES != WIDTH || CYCLES > (1 << DIV_CNT_W))
        begin : g_bad_cfg
            $error("mdm_div: STEPS*CYCLES must equal WIDTH");
        end
    endgenerate

    mdm_div_state_t           state;
    logic [DIV_CNT_W-1:0]     cnt;
    logic [WIDTH-1:0]         quo;
    logic [WIDTH:0]           rem;
    logic [WIDTH-1:0]         dsr;
    logic [WIDTH:0]           rem_s [0:STEPS];
    logic [WIDTH-1:0]         quo_s [0:STEPS];
    logic [WIDTH:0]           diff  [0:STEPS-1];

    // restoring stages, several quotient bits per clock
    assign rem_s[0] = rem;
    assign quo_s[0] = quo;
    genvar k;
    generate
        for (k = 0; k < STEPS; k++)
        begin : g_stage
            logic [WIDTH:0] shifted;
            assign shifted = {rem_s[k][WIDTH-1:0], quo_s[k][WIDTH-1]};
            assign diff[k] = shifted - {1'b0, dsr};
            assign rem_s[k+1] = diff[k][WIDTH] ? shifted : diff[k];
            assign quo_s[k+1] = {quo_s[k][WIDTH-2:0], ~diff[k][WIDTH]};
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= MDM_DIV_IDLE;
            cnt   <= '0;
            quo   <= '0;
            rem   <= '0;
            dsr   <= '0;
        end
        else
        begin
            case (state)
                MDM_DIV_IDLE, MDM_DIV_DONE:
                begin
                    if (i_start)
                    begin
                        state <= MDM_DIV_RUN;
                        cnt   <= '0;
                        quo   <= i_dividend;
                        rem   <= '0;
                        dsr   <= i_divisor;
                    end
                    else
                    begin
                        state <= MDM_DIV_IDLE;
                    end
                end
                MDM_DIV_RUN:
                begin
                    quo <= quo_s[STEPS];
                    rem <= rem_s[STEPS];
                    cnt <= cnt + 1'b1;
                    // last of the per-clock steps lands here
                    if (cnt == DIV_CNT_W'(CYCLES - 1))
                    begin
                        state <= MDM_DIV_DONE;
                    end
                end
                default:
                begin
                    state <= MDM_DIV_IDLE;
                end
            endcase
        end
    end

    // results held in flip-flops until the next division ends
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_quotient  <= '0;
            o_remainder <= '0;
            o_done      <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (state == MDM_DIV_RUN && cnt == DIV_CNT_W'(CYCLES - 1))
            begin
                o_quotient  <= quo_s[STEPS];
                o_remainder <= rem_s[STEPS][WIDTH-1:0];
                o_done      <= 1'b1;
            end
        end
    end

    assign o_busy = (state == MDM_DIV_RUN);

endmodule

// *** rtl/mdm_unit.sv ***
`timescale 1ns/1ps

module mdm_unit
(
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_nrst,
    input  wire logic                    i_start,
    input  wire mdm_pkg::mdm_op_t        i_op,
    input  wire logic                    i_signed,
    input  wire logic [15:0]             i_mul_a,
    input  wire logic [15:0]             i_mul_b,
    input  wire logic [31:0]             i_dividend,
    input  wire logic [31:0]             i_divisor,
    input  wire logic                    i_acc_wr,
    input  wire logic [31:0]             i_acc_wdata,
    input  wire logic                    i_flag_clr,
    output logic [31:0]                  o_product,
    output logic [31:0]                  o_acc,
    output logic [31:0]                  o_quotient,
    output logic [31:0]                  o_remainder,
    output logic                         o_busy,
    output logic                         o_mac_busy,
    output logic                         o_div_done,
    output logic                         o_ovf_flag,
    output logic                         o_udf_flag,
    output logic                         o_irq
);
    import mdm_pkg::*;

    logic                 start_mul;
    logic                 start_mac;
    logic                 start_div;
    logic                 div_busy;
    logic                 div_done;
    logic [33:0]          next_product;
    logic [31:0]          mac_prod;
    logic                 mac_signed;
    logic                 mac_pend;
    logic [32:0]          next_usum;
    logic [31:0]          next_acc;
    logic                 mac_ovf;
    logic                 mac_udf;
    logic                 mac_irq;

    // a start while the divider runs is ignored; divider operands were latched at its start
    assign start_mul = i_start && !div_busy && (i_op == MDM_OP_MUL);
    assign start_mac = i_start && !div_busy && (i_op == MDM_OP_MAC);
    assign start_div = i_start && !div_busy && (i_op == MDM_OP_DIV);

    // one 17x17 signed multiplier serves both signed and unsigned forms
    always_comb
    begin
        next_product = $signed({i_signed & i_mul_a[15], i_mul_a})
                     * $signed({i_signed & i_mul_b[15], i_mul_b});
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_product <= WIDE_RESET;
        end
        else if (start_mul || start_mac)
        begin
            o_product <= next_product[31:0];
        end
    end

    // accumulate is pipelined: product captured first, sum on next edge
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mac_prod   <= WIDE_RESET;
            mac_signed <= 1'b0;
            mac_pend   <= 1'b0;
        end
        else
        begin
            mac_pend <= start_mac;
            if (start_mac)
            begin
                mac_prod   <= next_product[31:0];
                mac_signed <= i_signed;
            end
        end
    end

    always_comb
    begin
        next_usum = {1'b0, o_acc} + {1'b0, mac_prod};
        next_acc  = next_usum[31:0];
        mac_ovf   = 1'b0;
        mac_udf   = 1'b0;
        if (mac_signed)
        begin
            // signed: like-signed operands giving an opposite-signed sum
            mac_ovf = !o_acc[31] && !mac_prod[31] && next_acc[31];
            mac_udf = o_acc[31] && mac_prod[31] && !next_acc[31];
        end
        else
        begin
            // unsigned product is never negative, so only carry-out matters
            mac_ovf = next_usum[32];
        end
    end

    // sum wraps modulo 2^32 on overflow; software decides what to do
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_acc <= ACC_RESET;
        end
        else if (mac_pend)
        begin
            o_acc <= next_acc;
        end
        else if (i_acc_wr)
        begin
            o_acc <= i_acc_wdata;
        end
    end

    // sticky cause flags; a new event wins over a clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_ovf_flag <= 1'b0;
            o_udf_flag <= 1'b0;
        end
        else
        begin
            o_ovf_flag <= (mac_pend && mac_ovf)
                       || (o_ovf_flag && !i_flag_clr);
            o_udf_flag <= (mac_pend && mac_udf)
                       || (o_udf_flag && !i_flag_clr);
        end
    end

    mdm_div
    #(
        .WIDTH  (WIDE_W),
        .STEPS  (DIV_BITS_PER_CYCLE),
        .CYCLES (DIV_CYCLES)
    )
    u_div
    (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_start     (start_div),
        .i_dividend  (i_dividend),
        .i_divisor   (i_divisor),
        .o_busy      (div_busy),
        .o_done      (div_done),
        .o_quotient  (o_quotient),
        .o_remainder (o_remainder)
    );

    // range event registered so it lines up with the sticky flags
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mac_irq <= 1'b0;
        end
        else
        begin
            mac_irq <= mac_pend && (mac_ovf || mac_udf);
        end
    end

    // shared line is an or of two flops, so it pulses with done itself
    assign o_irq = div_done || mac_irq;

    assign o_div_done = div_done;
    assign o_busy     = div_busy;
    assign o_mac_busy = mac_pend;

endmodule

// *** sim/mdm_cpu_model.sv ***
`timescale 1ns/1ps
// operands are scrambled after the start edge: a late sample shows up
module mdm_cpu_model
(
    input  wire logic        i_sys_clk,
    output mdm_pkg::mdm_op_t o_op,
    output logic             o_start,
    output logic             o_signed,
    output logic [15:0]      o_mul_a,
    output logic [15:0]      o_mul_b,
    output logic [31:0]      o_dividend,
    output logic [31:0]      o_divisor,
    output logic             o_acc_wr,
    output logic [31:0]      o_acc_wdata,
    output logic             o_flag_clr
);
    import mdm_pkg::*;
    initial
    begin
        {o_start, o_signed, o_acc_wr, o_flag_clr} = 4'h0;
        o_op = MDM_OP_MUL;
        {o_mul_a, o_mul_b, o_dividend, o_divisor, o_acc_wdata} = '0;
    end
    task automatic run(input mdm_op_t op, input logic sg,
                       input logic [31:0] a, input logic [31:0] b);
        @(negedge i_sys_clk);
        o_op = op;
        o_signed = sg;
        {o_mul_a, o_mul_b, o_dividend, o_divisor} = {a[15:0], b[15:0], a, b};
        o_start = 1'b1;
        @(negedge i_sys_clk);
        o_start = 1'b0;
        {o_mul_a, o_mul_b, o_dividend} = ~{o_mul_a, o_mul_b, o_dividend};
        o_divisor = ~o_divisor;
    endtask
    task automatic load(input logic [31:0] w);
        @(negedge i_sys_clk);
        {o_acc_wr, o_flag_clr, o_acc_wdata} = {2'b11, w};
        @(negedge i_sys_clk);
        {o_acc_wr, o_flag_clr, o_acc_wdata} = {2'b00, ~w};
    endtask
endmodule

// *** sim/mdm_unit_sva.sv ***
`timescale 1ns/1ps
module mdm_unit_chk
(
    input wire logic             i_sys_clk,
    input wire logic             i_nrst,
    input wire logic             i_start,
    input wire mdm_pkg::mdm_op_t i_op,
    input wire logic             i_signed,
    input wire logic [15:0]      i_mul_a,
    input wire logic [15:0]      i_mul_b,
    input wire logic             i_acc_wr,
    input wire logic             i_flag_clr,
    input wire logic [31:0]      o_product,
    input wire logic [31:0]      o_acc,
    input wire logic             o_busy,
    input wire logic             o_mac_busy,
    input wire logic             o_div_done,
    input wire logic             o_ovf_flag,
    input wire logic             o_udf_flag,
    input wire logic             o_irq
);
    import mdm_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    logic signed [31:0] sa, sb;
    logic               go;
    assign sa = i_signed ? {{16{i_mul_a[15]}}, i_mul_a} : {16'h0, i_mul_a};
    assign sb = i_signed ? {{16{i_mul_b[15]}}, i_mul_b} : {16'h0, i_mul_b};
    assign go = i_start && !o_busy;
    sequence s_mac;
        go && i_op == MDM_OP_MAC;
    endsequence
    sequence s_div;
        go && i_op == MDM_OP_DIV;
    endsequence
    AST_MUL_PROD: assert property (
        go && (i_op == MDM_OP_MUL || i_op == MDM_OP_MAC)
        |=> o_product == $past(sa * sb))
        else $error("product wrong one cycle after start");
    AST_MAC_SUM: assert property (
        s_mac ##1 !i_acc_wr |=> o_acc == $past(o_acc) + $past(o_product))
        else $error("accumulate sum wrong two cycles after start");
    AST_MAC_BUSY: assert property (s_mac |=> o_mac_busy)
        else $error("accumulate second cycle not flagged");
    AST_DIV_BUSY: assert property (s_div |=> o_busy [*8])
        else $error("divider not busy after start");
    AST_DIV_DONE: assert property (s_div |-> ##[16:17] o_div_done)
        else $error("division did not finish in time");
    AST_DONE_IRQ: assert property (o_div_done |-> o_irq)
        else $error("division end gave no interrupt");
    AST_IRQ_SRC: assert property (
        o_irq |-> o_div_done || $past(o_mac_busy))
        else $error("interrupt without division end or sum");
    AST_FLAG_IRQ: assert property (
        $rose(o_ovf_flag) || $rose(o_udf_flag) |-> o_irq)
        else $error("range flag set without interrupt");
    AST_FLAG_HOLD: assert property (
        $fell(o_ovf_flag) || $fell(o_udf_flag) |-> $past(i_flag_clr))
        else $error("range flag dropped without clear");
endmodule

// *** sim/mdm_unit_tb.sv ***
`timescale 1ns/1ps
module mdm_unit_tb;
    import mdm_pkg::*;
    logic i_sys_clk, i_nrst, i_start, i_signed, i_acc_wr, i_flag_clr;
    logic o_busy, o_mac_busy, o_div_done, o_ovf_flag, o_udf_flag, o_irq;
    logic [15:0] i_mul_a, i_mul_b;
    logic [31:0] i_dividend, i_divisor, i_acc_wdata;
    logic [31:0] o_product, o_acc, o_quotient, o_remainder;
    mdm_op_t     i_op;
    int          failures = 0;
    int          checks = 0;
    mdm_unit dut
    (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(i_start),
        .i_op(i_op), .i_signed(i_signed), .i_mul_a(i_mul_a),
        .i_mul_b(i_mul_b), .i_dividend(i_dividend), .i_divisor(i_divisor),
        .i_acc_wr(i_acc_wr), .i_acc_wdata(i_acc_wdata),
        .i_flag_clr(i_flag_clr), .o_product(o_product), .o_acc(o_acc),
        .o_quotient(o_quotient), .o_remainder(o_remainder),
        .o_busy(o_busy), .o_mac_busy(o_mac_busy), .o_div_done(o_div_done),
        .o_ovf_flag(o_ovf_flag), .o_udf_flag(o_udf_flag), .o_irq(o_irq)
    );
    mdm_cpu_model cpu
    (
        .i_sys_clk(i_sys_clk), .o_op(i_op), .o_start(i_start),
        .o_signed(i_signed), .o_mul_a(i_mul_a), .o_mul_b(i_mul_b),
        .o_dividend(i_dividend), .o_divisor(i_divisor),
        .o_acc_wr(i_acc_wr), .o_acc_wdata(i_acc_wdata),
        .o_flag_clr(i_flag_clr)
    );
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_mul;
        logic [64:0] tv [4] = '{{1'b1, 32'hffff_ffff, 32'h0000_0001},
            {1'b0, 32'hffff_ffff, 32'hfffe_0001},
            {1'b1, 32'h7fff_8000, 32'hc000_8000},
            {1'b0, 32'h8000_8000, 32'h4000_0000}};
        for (int i = 0; i < 4; i++)
        begin
            cpu.run(MDM_OP_MUL, tv[i][64], tv[i][63:48], tv[i][47:32]);
            cmp(o_product, tv[i][31:0]);
            cmp({31'h0, o_irq}, 32'h0);
        end
    endtask
    task automatic t_mac;
        logic [98:0] tv [4] = '{
            {1'b1, 32'h0001_0001, 32'h7fff_ffff, 32'h8000_0000, 2'b10},
            {1'b1, 32'hffff_0001, 32'h8000_0000, 32'h7fff_ffff, 2'b01},
            {1'b0, 32'h0001_0001, 32'hffff_ffff, 32'h0000_0000, 2'b10},
            {1'b1, 32'h0003_ffff, 32'h0000_0010, 32'h0000_000d, 2'b00}};
        for (int i = 0; i < 4; i++)
        begin
            cpu.load(tv[i][65:34]);
            cpu.run(MDM_OP_MAC, tv[i][98], tv[i][97:82], tv[i][81:66]);
            cmp({31'h0, o_mac_busy}, 32'h1);
            @(negedge i_sys_clk);
            cmp(o_acc, tv[i][33:2]);
            cmp({30'h0, o_ovf_flag, o_udf_flag}, {30'h0, tv[i][1:0]});
            cmp({31'h0, o_irq}, {31'h0, |tv[i][1:0]});
        end
    endtask
    task automatic t_div;
        logic [127:0] tv [3] = '{
            {32'h0000_0064, 32'h0000_0007, 32'h0000_000e, 32'h0000_0002},
            {32'hffff_ffff, 32'h0000_0010, 32'h0fff_ffff, 32'h0000_000f},
            {32'h1234_5678, 32'h0000_0000, 32'hffff_ffff, 32'h1234_5678}};
        for (int i = 0; i < 3; i++)
        begin
            cpu.run(MDM_OP_DIV, 1'b0, tv[i][127:96], tv[i][95:64]);
            cmp({31'h0, o_busy}, 32'h1);
            for (int n = 0; n < 20 && o_div_done !== 1'b1; n++)
                @(negedge i_sys_clk);
            cmp({31'h0, o_div_done}, 32'h1);
            cmp({31'h0, o_irq}, 32'h1);
            cmp({31'h0, o_busy}, 32'h0);
            cmp(o_quotient, tv[i][63:32]);
            cmp(o_remainder, tv[i][31:0]);
        end
    endtask
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        #20us;
        failures++;
        wrap_up;
    end
    initial
    begin
        i_nrst = 1'b0;
        repeat (8) @(negedge i_sys_clk);
        i_nrst = 1'b1;
        t_mul;
        t_mac;
        t_div;
        wrap_up;
    end
endmodule
bind mdm_unit mdm_unit_chk chk
(
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(i_start),
    .i_op(i_op), .i_signed(i_signed), .i_mul_a(i_mul_a),
    .i_mul_b(i_mul_b), .i_acc_wr(i_acc_wr), .i_flag_clr(i_flag_clr),
    .o_product(o_product), .o_acc(o_acc), .o_busy(o_busy),
    .o_mac_busy(o_mac_busy), .o_div_done(o_div_done),
    .o_ovf_flag(o_ovf_flag), .o_udf_flag(o_udf_flag), .o_irq(o_irq)
);
